// ### dv/tb.sv
// Purpose: self-checking bench for urd_top
// Assumes: urd_host_bfm as serial controller; line_i driven here
// Notes:   without pull-ups fitted both serial lines read low
module tb
  import urd_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys, rst_b, en_n, pu, scl, hoe_b;
  logic       sda_o, sda_oe_b, cd, hs, i2c_mode;
  logic [1:0] acs, dcs;
  urd_line_t  line;
  urd_comp_t  comp;
  int         error_cnt, tests_run, cyc;
  logic [2:0] acx [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [2:0] dcx [4] = '{3'h3, 3'h5, 3'h7, 3'h5};
  wire        sdl  = pu & hoe_b & (sda_oe_b | sda_o);
  wire        scll = pu & scl;

  urd_top DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .enable_reset_n_pin(en_n),
    .ac_boost_strap_pin(acs), .dc_gain_strap_pin(dcs), .line_i(line),
    .scl_i(scll), .sda_i(sdl), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
    .connection_detect_flag(cd), .high_speed_active_flag(hs),
    .i2c_mode(i2c_mode), .comp_o(comp));

  urd_host_bfm host (.clk_sys(clk_sys), .sda_in(sdl), .scl_out(scl),
    .sda_oe_b(hoe_b));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // serial traffic needs about 74k cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  task automatic chk_flag(input logic g, e, input string m);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk_flag

  task automatic chk_val(input logic [7:0] g, e, input string m);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk_val

  // shutdown, release with straps, then move the straps away
  task automatic power(input logic [1:0] a, d);
    en_n = 1'b0;
    wt(3);
    chk_flag(cd | hs | i2c_mode, 1'b0, "shutdown flags");
    chk_val({1'b0, comp}, 8'h05, "shutdown comp");
    acs = a;
    dcs = d;
    en_n = 1'b1;
    wt(1);
    acs = ~a;
    dcs = ~d;
    wt(4);
  endtask : power

  task automatic chirp(input int n);
    line.chirp_j = 1'b1;
    wt(n);
    line.chirp_j = 1'b0;
    line.chirp_k = 1'b1;
    wt(n);
    line.chirp_k = 1'b0;
    wt(3);
  endtask : chirp

  // ==========================================================
  // scenarios
  task automatic t_straps;
    for (int i = 0; i < 4; i++)
    begin
      power(2'(i), 2'(i));
      chk_flag(i2c_mode, 1'b0, "mode");
      chk_val({5'h0, comp.ac}, {5'h0, acx[i]}, "ac");
      chk_val({5'h0, comp.dc}, {5'h0, dcx[i]}, "dc");
    end
    $display("test straps done");
  endtask : t_straps

  task automatic t_speed;
    power(2'h3, 2'h1);
    line.a_pos_pu = 1'b1;
    wt(3);
    chk_flag(cd, 1'b1, "attach");
    chk_flag(comp.en | hs, 1'b0, "slow comp");
    chirp(449);
    chk_flag(hs, 1'b0, "short chirp");
    chirp(450);
    chk_flag(hs & comp.en, 1'b1, "hs");
    chk_val({1'b0, comp}, 8'h7D, "hs boosts");
    line = '0;
    wt(3);
    chk_flag(cd | hs, 1'b0, "detach");
    $display("test speed done");
  endtask : t_speed

  task automatic t_serial;
    logic [7:0] d, e;
    logic       k;
    pu = 1'b1;
    power(2'h2, 2'h2);
    chk_flag(i2c_mode, 1'b1, "serial mode");
    line.b_neg_pu = 1'b1;
    host.wr(7'h2D, 8'h03, 8'h00, k);
    chk_flag(k, 1'b1, "foreign address");
    chk_flag(cd | comp.en, 1'b0, "held");
    host.rd2(8'h02, e, d);
    chk_val(e, 8'h00, "reserved reads zero");
    chk_val(d, 8'h01, "hold reset");
    host.rd(8'h01, d);
    chk_val(d, 8'h30, "ac reg");
    host.rd(8'h0E, d);
    chk_val(d, 8'h07, "dc reg");
    host.rmw(8'h01, 8'h70, 8'h10);
    host.rd(8'h01, d);
    chk_val(d, 8'h10, "ac write");
    host.restart();
    wt(5);
    chk_flag(cd, 1'b1, "restart");
    chk_val({1'b0, comp}, 8'h0F, "new boosts");
    line = '0;
    pu = 1'b0;
    $display("test serial done");
  endtask : t_serial

  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial
  begin
    rst_b = 1'b0;
    en_n = 1'b0;
    pu = 1'b0;
    acs = 2'h0;
    dcs = 2'h0;
    line = '0;
    wt(16);
    rst_b = 1'b1;
    t_straps();
    t_speed();
    t_serial();
    results();
  end
endmodule : tb

// ### dv/urd_host_bfm.sv
// Purpose: serial bus controller model facing the register target
// Assumes: 25 MHz clk_sys, 100 kHz bus, lines pulled up by the bench
// Notes:   tasks are called from tb; changes land 1 ns after edges
module urd_host_bfm
#(
  parameter logic [6:0] ADDR = 7'h2C
)
(
  // clock
  input  wire logic clk_sys,
  // bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_b
);
  timeunit 1ns;
  timeprecision 100ps;

  // quarter bit: 4 * 62 cycles of 40 ns is close to 100 kHz
  localparam int Q = 62;

  initial
  begin
    scl_out  = 1'b1;
    sda_oe_b = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  // ==========================================================
  // bit and byte level
  // scl low on entry and exit; line sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_oe_b = b;
    wt(Q);
    scl_out = 1'b1;
    wt(Q);
    s = sda_in;
    wt(Q);
    scl_out = 1'b0;
    wt(Q);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] w, input logic m,
                         output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(m, a);
  endtask : byte_io

  task automatic start;
    sda_oe_b = 1'b1;
    wt(Q);
    scl_out = 1'b1;
    wt(Q);
    sda_oe_b = 1'b0;
    wt(Q);
    scl_out = 1'b0;
    wt(Q);
  endtask : start

  task automatic stop;
    sda_oe_b = 1'b0;
    wt(Q);
    scl_out = 1'b1;
    wt(Q);
    sda_oe_b = 1'b1;
    wt(Q);
  endtask : stop

  // ==========================================================
  // register transfers
  task automatic wr(input logic [6:0] a, input logic [7:0] o, d,
                    output logic ack);
    logic [7:0] r;
    logic       k;
    start();
    byte_io({a, 1'b0}, 1'b1, r, ack);
    if (ack === 1'b0)
    begin
      byte_io(o, 1'b1, r, k);
      byte_io(d, 1'b1, r, k);
    end
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] o, output logic [7:0] d);
    logic k;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, d, k);
    byte_io(o, 1'b1, d, k);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, d, k);
    // released ack bit reads as nack and ends the read
    byte_io(8'hFF, 1'b1, d, k);
    stop();
  endtask : rd

  // two bytes in one read: ack the first, nack the second
  task automatic rd2(input logic [7:0] o, output logic [7:0] d0, d1);
    logic [7:0] r;
    logic       k;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, r, k);
    byte_io(o, 1'b1, r, k);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, r, k);
    byte_io(8'hFF, 1'b0, d0, k);
    byte_io(8'hFF, 1'b1, d1, k);
    stop();
  endtask : rd2

  // reserved bits keep whatever the target reported
  task automatic rmw(input logic [7:0] o, mask, val);
    logic [7:0] d;
    logic       k;
    rd(o, d);
    wr(ADDR, o, (d & ~mask) | (val & mask), k);
  endtask : rmw

  // boost changes reach comp_o at once; the hold bit pulse only restarts detection
  task automatic restart;
    logic k;
    wr(ADDR, 8'h03, 8'h01, k);
    wr(ADDR, 8'h03, 8'h00, k);
  endtask : restart
endmodule : urd_host_bfm

// ### logic/urd_top.sv
// Purpose: strap latch, serial register target and speed detection
// Assumes: all inputs synchronous to clk_sys; analog front end digitises
//          strap levels, pull-ups and chirps
// Notes:   sda is open drain: sda_oe_b low pulls the line low
`include "urd_defines.svh"
module urd_top
  import urd_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst_b,
  // device pins
  input  wire logic      enable_reset_n_pin,
  input  wire logic [1:0] ac_boost_strap_pin,
  input  wire logic [1:0] dc_gain_strap_pin,
  input  wire urd_line_t line_i,
  // serial target
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe_b,
  // status and compensation
  output logic           connection_detect_flag,
  output logic           high_speed_active_flag,
  output logic           i2c_mode,
  output urd_comp_t      comp_o
);
  localparam logic [11:0] CMIN = 12'(`URD_CHIRP_MIN_CYC);
  localparam logic [11:0] CMAX = 12'(`URD_CHIRP_MAX_CYC);

  // ==========================================================
  // decode helpers
  function automatic logic [2:0] ac_code(input logic [1:0] lvl);
    case (lvl)
      2'h0:    ac_code = `URD_ACB_L0;
      2'h1:    ac_code = `URD_ACB_L1;
      2'h2:    ac_code = `URD_ACB_L2;
      default: ac_code = `URD_ACB_L3;
    endcase
  endfunction : ac_code

  // 00 low, 01 floating, 10 high; 11 treated as floating
  function automatic logic [2:0] dc_code(input logic [1:0] lvl);
    case (lvl)
      2'h0:    dc_code = `URD_DCB_40MV;
      2'h2:    dc_code = `URD_DCB_80MV;
      default: dc_code = `URD_DCB_60MV;
    endcase
  endfunction : dc_code

  // ==========================================================
  // registers and serial target
  logic       en_q, en_d, rel;
  logic       mode_q, mode_d;
  logic [2:0] acb_q, acb_d, dcb_q, dcb_d;
  logic       hold_q, hold_d;
  urd_i2c_t   ist_q, ist_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic       rw_q, rw_d, drv_q, drv_d;
  logic       scl_q, sda_q;
  logic       srise, sfall, start, stop;
  logic [7:0] rdat;

  assign rel   = enable_reset_n_pin & ~en_q;
  assign srise = scl_i & ~scl_q;
  assign sfall = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;

  // reserved bits read as zero and ignore writes
  always_comb
  begin
    rdat = 8'h00;
    case (ptr_q)
      `URD_OFS_ACB:  rdat[`URD_ACB_MSB:`URD_ACB_LSB] = acb_q;
      `URD_OFS_HOLD: rdat[`URD_HOLD_BIT] = hold_q;
      `URD_OFS_DCB:  rdat[`URD_DCB_MSB:`URD_DCB_LSB] = dcb_q;
      default:       rdat = 8'h00;
    endcase
  end

  always_comb
  begin
    en_d   = enable_reset_n_pin;
    mode_d = mode_q;
    acb_d  = acb_q;
    dcb_d  = dcb_q;
    hold_d = hold_q;
    ist_d  = ist_q;
    bcnt_d = bcnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    drv_d  = drv_q;
    if (rel)
    begin
      // straps read once here, never again until next release
      acb_d  = ac_code(ac_boost_strap_pin);
      dcb_d  = dc_code(dc_gain_strap_pin);
      mode_d = scl_i & sda_i;
      hold_d = scl_i & sda_i;
    end
    else if (mode_q)
    begin
      if (srise && bcnt_q != 4'h8)
      begin
        sh_d   = {sh_q[6:0], sda_i};
        bcnt_d = bcnt_q + 4'h1;
      end
      case (ist_q)
        URD_I_ADDR:
          if (sfall && bcnt_q == 4'h8)
          begin
            // answer only at our own address
            if (sh_q[7:1] == `URD_I2C_ADDR)
            begin
              ist_d = URD_I_AACK;
              rw_d  = sh_q[0];
              drv_d = 1'b1;
            end
            else
              ist_d = URD_I_IDLE;
          end
        URD_I_AACK:
          if (sfall)
          begin
            bcnt_d = 4'h0;
            if (rw_q)
            begin
              ist_d = URD_I_RDAT;
              sh_d  = rdat;
              drv_d = ~rdat[7];
            end
            else
            begin
              ist_d = URD_I_REG;
              drv_d = 1'b0;
            end
          end
        URD_I_REG:
          if (sfall && bcnt_q == 4'h8)
          begin
            ist_d = URD_I_RACK;
            ptr_d = sh_q;
            drv_d = 1'b1;
          end
        URD_I_RACK, URD_I_WACK:
          if (sfall)
          begin
            ist_d  = URD_I_WDAT;
            bcnt_d = 4'h0;
            drv_d  = 1'b0;
          end
        URD_I_WDAT:
          if (sfall && bcnt_q == 4'h8)
          begin
            ist_d = URD_I_WACK;
            drv_d = 1'b1;
            ptr_d = ptr_q + 8'h01;
            case (ptr_q)
              `URD_OFS_ACB:  acb_d = sh_q[`URD_ACB_MSB:`URD_ACB_LSB];
              `URD_OFS_HOLD: hold_d = sh_q[`URD_HOLD_BIT];
              `URD_OFS_DCB:  dcb_d = sh_q[`URD_DCB_MSB:`URD_DCB_LSB];
              default:       hold_d = hold_q;
            endcase
          end
        URD_I_RDAT:
          if (sfall)
          begin
            if (bcnt_q == 4'h8)
            begin
              // byte done: step so rdat already holds the next register
              ist_d = URD_I_MACK;
              drv_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
            end
            else
              drv_d = ~sh_q[7]; // rising edge already shifted sh_q
          end
        URD_I_MACK:
          if (srise)
            rw_d = ~sda_i;
          else if (sfall)
          begin
            bcnt_d = 4'h0;
            if (rw_q)
            begin
              // controller acked: stream the next register
              ist_d = URD_I_RDAT;
              sh_d  = rdat;
              drv_d = ~rdat[7];
              rw_d  = 1'b1;
            end
            else
              ist_d = URD_I_IDLE;
          end
        default: ist_d = ist_q;
      endcase
      if (start)
      begin
        ist_d  = URD_I_ADDR;
        bcnt_d = 4'h0;
        drv_d  = 1'b0;
      end
      else if (stop)
      begin
        ist_d = URD_I_IDLE;
        drv_d = 1'b0;
      end
    end
    if (!enable_reset_n_pin)
    begin
      mode_d = 1'b0;
      acb_d  = `URD_ACB_L0;
      dcb_d  = `URD_DCB_60MV;
      hold_d = `URD_HOLD_RST;
      ist_d  = URD_I_IDLE;
      bcnt_d = 4'h0;
      sh_d   = 8'h00;
      ptr_d  = 8'h00;
      rw_d   = 1'b0;
      drv_d  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q   <= 1'b0;
      mode_q <= 1'b0;
      acb_q  <= `URD_ACB_L0;
      dcb_q  <= `URD_DCB_60MV;
      hold_q <= `URD_HOLD_RST;
      ist_q  <= URD_I_IDLE;
      bcnt_q <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      drv_q  <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end
    else
    begin
      en_q   <= en_d;
      mode_q <= mode_d;
      acb_q  <= acb_d;
      dcb_q  <= dcb_d;
      hold_q <= hold_d;
      ist_q  <= ist_d;
      bcnt_q <= bcnt_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      rw_q   <= rw_d;
      drv_q  <= drv_d;
      scl_q  <= scl_i;
      sda_q  <= sda_i;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_b = ~drv_q;
  assign i2c_mode = mode_q;

  // ==========================================================
  // speed detection
  urd_spd_t   spd_q, spd_d;
  logic [11:0] cnt_q, cnt_d;
  logic        att, in_rng;
  urd_comp_t   comp_d;
  logic        cd_d, hs_d;

  // either pair may face the host
  assign att    = line_i.a_pos_pu | line_i.a_neg_pu |
                  line_i.b_pos_pu | line_i.b_neg_pu;
  assign in_rng = cnt_q >= CMIN && cnt_q <= CMAX;

  always_comb
  begin
    spd_d = spd_q;
    cnt_d = cnt_q;
    case (spd_q)
      URD_S_OFF:  spd_d = URD_S_DISC;
      URD_S_DISC: if (att) spd_d = URD_S_CONN;
      URD_S_CONN:
        if (line_i.chirp_j)
        begin
          spd_d = URD_S_CHJ;
          cnt_d = 12'h001;
        end
      URD_S_CHJ, URD_S_CHK:
        if ((spd_q == URD_S_CHJ) ? line_i.chirp_j : line_i.chirp_k)
        begin
          // saturate past the window, still a failure
          if (cnt_q <= CMAX) cnt_d = cnt_q + 12'h001;
        end
        else if (!in_rng)
          spd_d = URD_S_CONN;
        else if (spd_q == URD_S_CHK)
          spd_d = URD_S_HS;
        else if (line_i.chirp_k)
        begin
          spd_d = URD_S_CHK;
          cnt_d = 12'h001;
        end
        else
          spd_d = URD_S_CONN;
      URD_S_HS:   spd_d = URD_S_HS;
      default:    spd_d = URD_S_OFF;
    endcase
    if (spd_q != URD_S_OFF && spd_q != URD_S_DISC && !att)
      spd_d = URD_S_DISC;
    // hold parks detection; clearing it restarts from disconnected
    if (hold_q || !enable_reset_n_pin || rel)
    begin
      spd_d = URD_S_OFF;
      cnt_d = 12'h000;
    end
    cd_d      = spd_d != URD_S_OFF && spd_d != URD_S_DISC;
    hs_d      = spd_d == URD_S_HS;
    comp_d.en = hs_d;
    comp_d.ac = acb_d;
    comp_d.dc = dcb_d;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spd_q                  <= URD_S_OFF;
      cnt_q                  <= 12'h000;
      connection_detect_flag <= 1'b0;
      high_speed_active_flag <= 1'b0;
      comp_o                 <= '0;
    end
    else
    begin
      spd_q                  <= spd_d;
      cnt_q                  <= cnt_d;
      connection_detect_flag <= cd_d;
      high_speed_active_flag <= hs_d;
      comp_o                 <= comp_d;
    end
  end

  // ==========================================================
  // checks
  chk_shut_no_cd: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !enable_reset_n_pin |=> !connection_detect_flag && !comp_o.en)
    else $error("flag or compensation active in shutdown");
  chk_comp_hs_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    comp_o.en |-> spd_q == URD_S_HS && connection_detect_flag)
    else $error("compensation outside high speed");
  chk_hold_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    hold_q |=> !comp_o.en && !connection_detect_flag)
    else $error("activity while hold is set");
  chk_hold_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rel && !(scl_i && sda_i) |=> !hold_q && !mode_q)
    else $error("hold not cleared outside serial mode");
  chk_hold_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rel && scl_i && sda_i |=> hold_q && mode_q)
    else $error("serial mode not entered");
  chk_ac_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rel && ac_boost_strap_pin == 2'h2 |=> acb_q == 3'h3)
    else $error("ac strap level 2 mislatched");
  chk_dc_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rel && dc_gain_strap_pin == 2'h0 |=> dcb_q == 3'h3)
    else $error("dc strap low mislatched");
  chk_strap_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mode_q && en_q && enable_reset_n_pin |=> $stable(acb_q)
    && $stable(dcb_q))
    else $error("boost changed without release");
  chk_chirp_short: assert property (@(posedge clk_sys) disable iff (!rst_b)
    spd_q == URD_S_CHJ && !line_i.chirp_j && cnt_q < CMIN
    |=> spd_q != URD_S_CHK)
    else $error("short chirp accepted");
endmodule : urd_top

// ### pkg/urd_defines.svh
// Purpose: constants of the redriver config and mode control block
// Assumes: 25 MHz clk_sys
// Notes:   included by urd_top only
`ifndef URD_DEFINES_SVH
`define URD_DEFINES_SVH
`define URD_I2C_ADDR     7'h2C
`define URD_OFS_ACB      8'h01
`define URD_OFS_HOLD     8'h03
`define URD_OFS_DCB      8'h0E
`define URD_ACB_MSB      6
`define URD_ACB_LSB      4
`define URD_DCB_MSB      2
`define URD_DCB_LSB      0
`define URD_HOLD_BIT     0
`define URD_ACB_L0       3'h0
`define URD_ACB_L1       3'h1
`define URD_ACB_L2       3'h3
`define URD_ACB_L3       3'h7
`define URD_DCB_40MV     3'h3
`define URD_DCB_60MV     3'h5
`define URD_DCB_80MV     3'h7
`define URD_HOLD_RST     1'h1
`define URD_CLK_NS       40
`define URD_CHIRP_MIN_US 18
`define URD_CHIRP_MAX_US 128
`define URD_CHIRP_MIN_CYC \
  ((`URD_CHIRP_MIN_US * 1000 + `URD_CLK_NS - 1) / `URD_CLK_NS)
`define URD_CHIRP_MAX_CYC ((`URD_CHIRP_MAX_US * 1000) / `URD_CLK_NS)
`endif

// ### pkg/urd_pkg.sv
// Purpose: types of the redriver config and mode control block
// Assumes: nothing
// Notes:   none
package urd_pkg;
  typedef enum logic [2:0] {
    URD_S_OFF   = 3'h0,
    URD_S_DISC  = 3'h1,
    URD_S_CONN  = 3'h3,
    URD_S_CHJ   = 3'h2,
    URD_S_CHK   = 3'h6,
    URD_S_HS    = 3'h7
  } urd_spd_t;
  typedef enum logic [3:0] {
    URD_I_IDLE = 4'h0,
    URD_I_ADDR = 4'h1,
    URD_I_AACK = 4'h3,
    URD_I_REG  = 4'h2,
    URD_I_RACK = 4'h6,
    URD_I_WDAT = 4'h7,
    URD_I_WACK = 4'h5,
    URD_I_RDAT = 4'hC,
    URD_I_MACK = 4'hD
  } urd_i2c_t;
  typedef struct packed {
    logic a_pos_pu;
    logic a_neg_pu;
    logic b_pos_pu;
    logic b_neg_pu;
    logic chirp_j;
    logic chirp_k;
  } urd_line_t;
  typedef struct packed {
    logic       en;
    logic [2:0] ac;
    logic [2:0] dc;
  } urd_comp_t;
endpackage : urd_pkg
